// ===== shared/pin_irq_pkg.sv
package pin_irq_pkg;

  localparam int NUM_CH    = 8;
  localparam int NUM_PORTS = 4;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int REG_W     = 8;
  localparam int SYNC_W    = NUM_CH * NUM_PORTS;

  // register indices; byte address is four times the index
  localparam logic [9:0] CONTROL_IDX     = 10'h0E9;
  localparam logic [9:0] FALL_EN_IDX     = 10'h0EA;
  localparam logic [9:0] RISE_EN_IDX     = 10'h0EB;
  localparam logic [9:0] FLAGS_IDX       = 10'h0EC;
  localparam logic [9:0] IRQ_STATUS_IDX  = 10'h0F0;
  localparam logic [9:0] IRQ_CLEAR_IDX   = 10'h0F1;
  localparam logic [9:0] IRQ_ENABLE_IDX  = 10'h0F2;

  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] FALL_EN_RST     = 8'h00;
  localparam logic [7:0] RISE_EN_RST     = 8'h00;
  localparam logic [7:0] FLAGS_RST       = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST  = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST  = 8'h00;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
  localparam logic [31:0] SYNC_RST       = 32'hFFFF_FFFF;

  // channel type: 0 level, 1 edge
  localparam logic TYPE_LEVEL = 1'b0;
  localparam logic TYPE_EDGE  = 1'b1;

  typedef struct packed {
    logic       type_sel_ch6_ch7;
    logic       type_sel_ch4_ch5;
    logic [3:0] channel_type_sel;
    logic [1:0] port_select;
  } channel_control_s;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } avl_req_s;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;

endpackage : pin_irq_pkg

// ===== hdl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int               WIDTH   = 32,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = ce_i ? async_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule : pin_sync

`default_nettype wire

// ===== hdl/pin_change_interrupt.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module pin_change_interrupt (
  input  wire logic                                 mclk_i,
  input  wire logic                                 rst_b_i,
  input  wire logic                                 ce_i,
  input  wire pin_irq_pkg::avl_req_s                avl_i,
  output logic                                      avl_waitrequest_o,
  output logic [pin_irq_pkg::DATA_W-1:0]            avl_readdata_o,
  input  wire logic [pin_irq_pkg::SYNC_W-1:0]       port_pins_i,
  output logic                                      cpu_req_o,
  output logic                                      irq_o,
  output logic                                      wake_o
);

  import pin_irq_pkg::*;

  bus_state_e        bus_state_reg;
  bus_state_e        bus_state_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;

  channel_control_s  channel_control_reg;
  channel_control_s  channel_control_next;
  logic [REG_W-1:0]  negative_polarity_enables_reg;
  logic [REG_W-1:0]  negative_polarity_enables_next;
  logic [REG_W-1:0]  positive_polarity_enables_reg;
  logic [REG_W-1:0]  positive_polarity_enables_next;
  logic [REG_W-1:0]  channel_flags_reg;
  logic [REG_W-1:0]  channel_flags_next;
  logic [REG_W-1:0]  irq_status_reg;
  logic [REG_W-1:0]  irq_status_next;
  logic [REG_W-1:0]  irq_enable_reg;
  logic [REG_W-1:0]  irq_enable_next;
  logic [REG_W-1:0]  prev_sample_reg;
  logic [REG_W-1:0]  prev_sample_next;

  logic [SYNC_W-1:0] pins_sync;
  logic [REG_W-1:0]  sel_sync;
  logic [REG_W-1:0]  sel_raw;
  logic [REG_W-1:0]  channel_type;
  logic [REG_W-1:0]  rise_seen;
  logic [REG_W-1:0]  fall_seen;
  logic [REG_W-1:0]  edge_hit;
  logic [REG_W-1:0]  flag_wr_mask;
  logic [REG_W-1:0]  clear_mask;
  logic [REG_W-1:0]  wake_hit;
  logic [9:0]        word_idx;
  logic              req;
  logic              done;
  logic              wr_en;
  logic              wr_control;
  logic              wr_fall_en;
  logic              wr_rise_en;
  logic              wr_flags;
  logic              wr_clear;
  logic              wr_irq_en;

  // two-stage synchroniser
  // pins idle high, so the synchroniser resets to that level
  pin_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) pin_sync_inst (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .async_i (port_pins_i),
    .sync_o  (pins_sync)
  );

  always_comb
  begin
    case (channel_control_reg.port_select)
      2'h0:    sel_sync = pins_sync[7:0];
      2'h1:    sel_sync = pins_sync[15:8];
      2'h2:    sel_sync = pins_sync[23:16];
      2'h3:    sel_sync = pins_sync[31:24];
      default: sel_sync = pins_sync[7:0];
    endcase
  end

  // raw selected pins feed only the clockless wake path
  always_comb
  begin
    case (channel_control_reg.port_select)
      2'h0:    sel_raw = port_pins_i[7:0];
      2'h1:    sel_raw = port_pins_i[15:8];
      2'h2:    sel_raw = port_pins_i[23:16];
      2'h3:    sel_raw = port_pins_i[31:24];
      default: sel_raw = port_pins_i[7:0];
    endcase
  end

  // expand type bits, ch4/ch5 and ch6/ch7 pairs share one bit each
  assign channel_type = {channel_control_reg.type_sel_ch6_ch7,
                         channel_control_reg.type_sel_ch6_ch7,
                         channel_control_reg.type_sel_ch4_ch5,
                         channel_control_reg.type_sel_ch4_ch5,
                         channel_control_reg.channel_type_sel};

  assign rise_seen = sel_sync & ~prev_sample_reg;
  assign fall_seen = ~sel_sync & prev_sample_reg;
  assign prev_sample_next = ce_i ? sel_sync : prev_sample_reg;

  // bus handshake: one wait cycle, answer on the second
  assign req      = avl_i.read | avl_i.write;
  assign word_idx = avl_i.address[ADDR_W-1:2];
  assign done     = req & (bus_state_reg == BUS_ACK) & ce_i;
  assign wr_en    = done & avl_i.write & avl_i.byteenable[0];
  assign avl_waitrequest_o = req & ~done;
  assign avl_readdata_o    = readdata_reg;

  always_comb
  begin
    bus_state_next = bus_state_reg;
    readdata_next  = readdata_reg;
    if (ce_i)
    begin
      case (bus_state_reg)
        BUS_IDLE:
        begin
          if (req)
          begin
            bus_state_next = BUS_ACK;
            // capture now so the data stand while waitrequest is low
            case (word_idx)
              CONTROL_IDX:    readdata_next = {24'h000000, channel_control_reg};
              FALL_EN_IDX:    readdata_next = {24'h000000, negative_polarity_enables_reg};
              RISE_EN_IDX:    readdata_next = {24'h000000, positive_polarity_enables_reg};
              FLAGS_IDX:      readdata_next = {24'h000000, channel_flags_reg};
              IRQ_STATUS_IDX: readdata_next = {24'h000000, irq_status_reg};
              IRQ_ENABLE_IDX: readdata_next = {24'h000000, irq_enable_reg};
              default:        readdata_next = READ_ZERO;
            endcase
          end
        end
        BUS_ACK:
        begin
          bus_state_next = BUS_IDLE;
        end
        default:
        begin
          bus_state_next = BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_state_reg <= BUS_IDLE;
      readdata_reg  <= READ_ZERO;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      readdata_reg  <= readdata_next;
    end
  end

  // configuration registers
  always_comb
  begin
    channel_control_next           = channel_control_reg;
    negative_polarity_enables_next = negative_polarity_enables_reg;
    positive_polarity_enables_next = positive_polarity_enables_reg;
    irq_enable_next                = irq_enable_reg;
    if (wr_control)
      channel_control_next = channel_control_s'(avl_i.writedata[7:0]);
    if (wr_fall_en)
      negative_polarity_enables_next = avl_i.writedata[7:0];
    if (wr_rise_en)
      positive_polarity_enables_next = avl_i.writedata[7:0];
    if (wr_irq_en)
      irq_enable_next = avl_i.writedata[7:0];
  end

  // one write strobe per register except IRQ status, only on the answering edge
  always_comb
  begin
    wr_control = 1'b0;
    wr_fall_en = 1'b0;
    wr_rise_en = 1'b0;
    wr_flags   = 1'b0;
    wr_clear   = 1'b0;
    wr_irq_en  = 1'b0;
    if (wr_en)
    begin
      case (word_idx)
        CONTROL_IDX:    wr_control = 1'b1;
        FALL_EN_IDX:    wr_fall_en = 1'b1;
        RISE_EN_IDX:    wr_rise_en = 1'b1;
        FLAGS_IDX:      wr_flags   = 1'b1;
        IRQ_CLEAR_IDX:  wr_clear   = 1'b1;
        IRQ_ENABLE_IDX: wr_irq_en  = 1'b1;
        default:        wr_control = 1'b0;
      endcase
    end
  end

  // writing 0 to an edge flag bit clears it; writing 1 leaves it
  assign flag_wr_mask = wr_flags ? ~avl_i.writedata[7:0] : 8'h00;
  assign clear_mask   = wr_clear ? avl_i.writedata[7:0] : 8'h00;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic flag_next;
      logic status_next;

      assign edge_hit[ch] = (rise_seen[ch] & positive_polarity_enables_reg[ch])
                          | (fall_seen[ch] & negative_polarity_enables_reg[ch]);

      // clockless detection of enabled pin conditions
      assign wake_hit[ch] = (channel_type[ch] == TYPE_LEVEL)
        ? ((~sel_raw[ch] & negative_polarity_enables_reg[ch])
         | (sel_raw[ch] & positive_polarity_enables_reg[ch]))
        : ((~sel_raw[ch] & prev_sample_reg[ch] & negative_polarity_enables_reg[ch])
         | (sel_raw[ch] & ~prev_sample_reg[ch] & positive_polarity_enables_reg[ch]));

      always_comb
      begin
        flag_next   = channel_flags_reg[ch];
        status_next = irq_status_reg[ch];
        if (ce_i)
        begin
          if (channel_type[ch] == TYPE_LEVEL)
          begin
            flag_next = ~sel_sync[ch];
          end
          else
          begin
            // sticky edge flag, set beats clear
            flag_next = edge_hit[ch] | (channel_flags_reg[ch] & ~flag_wr_mask[ch]);
          end
          // status sticky, set beats clear
          status_next = channel_flags_reg[ch] | (irq_status_reg[ch] & ~clear_mask[ch]);
        end
      end

      // each channel owns one bit of the shared next-value vectors
      assign channel_flags_next[ch] = flag_next;
      assign irq_status_next[ch]    = status_next;
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      channel_control_reg           <= channel_control_s'(CONTROL_RST);
      negative_polarity_enables_reg <= FALL_EN_RST;
      positive_polarity_enables_reg <= RISE_EN_RST;
      channel_flags_reg             <= FLAGS_RST;
      irq_status_reg                <= IRQ_STATUS_RST;
      irq_enable_reg                <= IRQ_ENABLE_RST;
      // previous sample starts at the idle pin level, so no false edge
      prev_sample_reg               <= SYNC_RST[REG_W-1:0];
    end
    else
    begin
      channel_control_reg           <= channel_control_next;
      negative_polarity_enables_reg <= negative_polarity_enables_next;
      positive_polarity_enables_reg <= positive_polarity_enables_next;
      channel_flags_reg             <= channel_flags_next;
      irq_status_reg                <= irq_status_next;
      irq_enable_reg                <= irq_enable_next;
      prev_sample_reg               <= prev_sample_next;
    end
  end

  assign cpu_req_o = |(channel_flags_reg & (negative_polarity_enables_reg | positive_polarity_enables_reg));
  assign irq_o     = |(irq_status_reg & irq_enable_reg);
  // raw-pin path may glitch; treat wake_o as a wake strobe only
  assign wake_o    = |wake_hit;

endmodule : pin_change_interrupt

`default_nettype wire

// ===== tb/keypad_model.sv
`timescale 1ns/1ns
`default_nettype none
module keypad_model (
  input  wire logic        mclk_i,
  input  wire logic [31:0] press_i,
  output logic      [31:0] pins_o
);
  // keys pull their pins low against pull-ups
  always_ff @(posedge mclk_i)
    pins_o <= ~press_i;
endmodule : keypad_model
`default_nettype wire

// ===== tb/pin_irq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pin_irq_monitor (
  input wire logic                        mclk_i,
  input wire logic                        rst_b_i,
  input wire logic                        ce_i,
  input wire pin_irq_pkg::avl_req_s       avl_i,
  input wire logic                        avl_waitrequest_o,
  input wire logic [pin_irq_pkg::DATA_W-1:0] avl_readdata_o,
  input wire logic [pin_irq_pkg::SYNC_W-1:0] port_pins_i,
  input wire logic                        cpu_req_o,
  input wire logic                        irq_o,
  input wire logic                        wake_o
);
  import pin_irq_pkg::*;
  logic       rq;
  logic       wr;
  logic       rd;
  logic [9:0] ix;
  logic [7:0] ctl, ien, ne, pe;
  logic [2:0] qt;
  logic [31:0] pins_d;
  assign rq = avl_i.read | avl_i.write;
  assign wr = avl_i.write & ~avl_waitrequest_o & avl_i.byteenable[0];
  assign rd = avl_i.read & ~avl_waitrequest_o;
  assign ix = avl_i.address[11:2];
  always_ff @(posedge mclk_i)
    pins_d <= port_pins_i;
  // shadows of written settings; qt counts quiet cycles
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      {ctl, ien, ne, pe} <= '0;
      qt <= 3'h0;
    end
    else
    begin
      qt <= (port_pins_i != pins_d || wr) ? 3'h0 : qt + {2'h0, qt != 3'h7};
      if (wr && ix == CONTROL_IDX) ctl <= avl_i.writedata[7:0];
      if (wr && ix == IRQ_ENABLE_IDX) ien <= avl_i.writedata[7:0];
      if (wr && ix == FALL_EN_IDX) ne <= avl_i.writedata[7:0];
      if (wr && ix == RISE_EN_IDX) pe <= avl_i.writedata[7:0];
    end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wait_one_a: assert property (($rose(rq) && ce_i) ##1 ce_i |-> $past(avl_waitrequest_o) && !avl_waitrequest_o)
    else $error("wait cycle count wrong");
  idle_nowait_a: assert property (!rq |-> !avl_waitrequest_o)
    else $error("waitrequest high while idle");
  high_zero_a: assert property (rd |-> avl_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  level_follow_a: assert property (rd && ix == FLAGS_IDX && ctl[7:2] == 6'h00 && qt == 3'h7
    |-> avl_readdata_o[7:0] == ~port_pins_i[{ctl[1:0], 3'h0} +: 8]) else $error("level flags not inverse pins");
  irq_mask_a: assert property (ien == 8'h00 |-> !irq_o)
    else $error("irq while all masked");
  cpu_gate_a: assert property ((ne | pe) == 8'h00 |-> !cpu_req_o)
    else $error("cpu request with no enables");
  wake_gate_a: assert property ((ne | pe) == 8'h00 |-> !wake_o)
    else $error("wake with no enables");
  reset_quiet_a: assert property ($rose(rst_b_i) |-> !cpu_req_o && !irq_o && !wake_o)
    else $error("outputs active after reset");
  cover property (irq_o);
  cover property (cpu_req_o);
  cover property (wake_o && !ce_i);
endmodule : pin_irq_monitor
bind pin_change_interrupt pin_irq_monitor pin_irq_monitor_inst (.mclk_i, .rst_b_i, .ce_i, .avl_i,
  .avl_waitrequest_o, .avl_readdata_o, .port_pins_i, .cpu_req_o, .irq_o, .wake_o);
`default_nettype wire

// ===== tb/pin_change_interrupt_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pin_change_interrupt_tb_top;
  import pin_irq_pkg::*;
  logic              mclk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              ce_i = 1'b1;
  avl_req_s          avl_i = '0;
  logic              avl_waitrequest_o, cpu_req_o, irq_o, wake_o;
  logic [DATA_W-1:0] avl_readdata_o;
  logic [SYNC_W-1:0] port_pins_i;
  logic [SYNC_W-1:0] press = '0;
  logic [7:0]        exp_q[$];
  logic [9:0]        ixs[7] = '{CONTROL_IDX, FALL_EN_IDX, RISE_EN_IDX, FLAGS_IDX, IRQ_STATUS_IDX,
                                IRQ_ENABLE_IDX, 10'h100};
  int                fail_count = 0;
  int                n_compared = 0;
  always #20 mclk_i = ~mclk_i;
  keypad_model keypad_model_inst (.mclk_i, .press_i(press), .pins_o(port_pins_i));
  pin_change_interrupt pin_change_interrupt_inst (.mclk_i, .rst_b_i, .ce_i, .avl_i, .avl_waitrequest_o,
    .avl_readdata_o, .port_pins_i, .cpu_req_o, .irq_o, .wake_o);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic r, input logic [9:0] ix, input logic [7:0] d);
    @(posedge mclk_i);
    avl_i <= '{r, !r, {ix, 2'h0}, 4'hF, {24'h0, d}};
    do
      @(posedge mclk_i);
    while (avl_waitrequest_o !== 1'b0);
    avl_i.read <= 1'b0;
    avl_i.write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    bus(1'b0, ix, d);
  endtask : wr
  task automatic rd(input logic [9:0] ix, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b1, ix, 8'h00);
  endtask : rd
  // m selects among cpu request, irq and wake
  task automatic chk_out(input logic [2:0] m, input logic [2:0] e);
    @(negedge mclk_i);
    cmp({5'h0, {cpu_req_o, irq_o, wake_o} & m}, {5'h0, e});
  endtask : chk_out
  // read results are matched in issue order
  always @(posedge mclk_i)
    if (avl_i.read && avl_waitrequest_o === 1'b0 && exp_q.size() > 0)
      cmp(avl_readdata_o[7:0], exp_q.pop_front());
  task automatic give_verdict;
    if (exp_q.size() != 0)
    begin
      fail_count++;
      $display("BAD %0t %0d reads never answered", $time, exp_q.size());
    end
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    #200000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
  initial
  begin
    int s;
    s = $urandom(80200);
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (ixs[i]) rd(ixs[i], 8'h00);
    chk_out(3'b111, 3'b000);
    $display("reset values done");
    for (int p = 0; p < 4; p++)
    begin
      @(posedge mclk_i);
      press <= $urandom();
      wr(CONTROL_IDX, 8'(p));
      repeat (8) @(posedge mclk_i);
      rd(FLAGS_IDX, press[8*p +: 8]);
      wr(FLAGS_IDX, 8'h00);
      rd(FLAGS_IDX, press[8*p +: 8]);
    end
    $display("level and port select done");
    press <= '0;
    repeat (8) @(posedge mclk_i);
    wr(CONTROL_IDX, 8'h7C);
    wr(FALL_EN_IDX, 8'h0F);
    wr(RISE_EN_IDX, 8'h30);
    wr(FLAGS_IDX, 8'h00);
    press <= 32'h0000_00FF;
    repeat (8) @(posedge mclk_i);
    rd(FLAGS_IDX, 8'hCF);
    press <= '0;
    repeat (8) @(posedge mclk_i);
    rd(FLAGS_IDX, 8'h3F);
    chk_out(3'b110, 3'b100);
    wr(FLAGS_IDX, 8'hF0);
    rd(FLAGS_IDX, 8'h30);
    wr(FLAGS_IDX, 8'h00);
    rd(FLAGS_IDX, 8'h00);
    chk_out(3'b110, 3'b000);
    $display("edge flags done");
    rd(IRQ_STATUS_IDX, 8'hFF);
    wr(IRQ_ENABLE_IDX, 8'h01);
    chk_out(3'b010, 3'b010);
    wr(IRQ_ENABLE_IDX, 8'h00);
    chk_out(3'b010, 3'b000);
    wr(IRQ_ENABLE_IDX, 8'hFF);
    wr(IRQ_CLEAR_IDX, 8'hFF);
    rd(IRQ_STATUS_IDX, 8'h00);
    rd(IRQ_CLEAR_IDX, 8'h00);
    chk_out(3'b010, 3'b000);
    $display("interrupt status done");
    wr(FALL_EN_IDX, 8'h01);
    wr(RISE_EN_IDX, 8'h00);
    ce_i <= 1'b0;
    chk_out(3'b001, 3'b000);
    @(posedge mclk_i);
    press <= 32'h0000_0001;
    repeat (3) @(posedge mclk_i);
    chk_out(3'b001, 3'b001);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    $display("stopped clock wake done");
    give_verdict();
  end
endmodule : pin_change_interrupt_tb_top
`default_nettype wire
